/* include/ret_rot_pkg.sv */
// Purpose: shared constants and carriers for the return / rotate executor
// Assumes: 14-bit instruction words, 8-bit data, 13-bit program counter
// Notes:   one clock edge is one instruction cycle
`default_nettype none
package ret_rot_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int PC_W    = 13;
  localparam int FADDR_W = 7;

  // ****************************************
  // encodings and field positions
  // ****************************************
  localparam logic [13:0] OPC_RETURN     = 14'h0008;
  localparam logic [5:0]  OPC_ROT_LEFT   = 6'h0d;
  localparam logic [5:0]  OPC_ROT_RIGHT  = 6'h0c;
  localparam int          OPC_HI         = 13;
  localparam int          OPC_LO         = 8;
  localparam int          DEST_BIT       = 7;
  localparam int          FADDR_HI       = 6;
  localparam logic        DEST_TO_W      = 1'b0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [12:0] PC_RST   = 13'h0000;
  localparam logic [7:0]  DATA_RST = 8'h00;
  localparam logic [6:0]  FADR_RST = 7'h00;

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [0:0] {PH_FETCH, PH_RET_NOP} phase_e;

  typedef struct packed {
    phase_e      phase;
    logic        pop;
    logic        pc_load;
    logic [12:0] pc;
    logic        w_we;
    logic        f_we;
    logic [6:0]  f_addr;
    logic [7:0]  result;
    logic        c_we;
    logic        c_val;
  } exec_s;

  localparam exec_s EXEC_RST = '{phase: PH_FETCH, pop: 1'b0, pc_load: 1'b0, pc: PC_RST,
                                 w_we: 1'b0, f_we: 1'b0, f_addr: FADR_RST,
                                 result: DATA_RST, c_we: 1'b0, c_val: 1'b0};

endpackage
`default_nettype wire

/* verilog/rotate_unit.sv */
// Purpose: rotate an 8-bit value one place through the carry
// Assumes: purely combinational, used inside one instruction cycle
// Notes:   direction 1 rotates toward the msb
`timescale 1ns/1ps
`default_nettype none
module rotate_unit (
  input  wire logic       to_left,
  input  wire logic [7:0] data_in,
  input  wire logic       carry_in,
  output logic      [7:0] data_out,
  output logic            carry_out
);

  always_comb begin
    if (to_left) begin
      data_out  = {data_in[6:0], carry_in};
      carry_out = data_in[7];
    end else begin
      data_out  = {carry_in, data_in[7:1]};
      carry_out = data_in[0];
    end
  end

endmodule
`default_nettype wire

/* verilog/return_and_rotate_exec.sv */
// Purpose: decode and execute return, rotate-left and rotate-right through carry
// Assumes: stack, file registers and status live outside; same clock
// Notes:   results appear one edge after the instruction is taken
//
// How it works
// - return pops stack into pc, flags untouched
// - return takes two cycles, second does nothing
// - rotate left: carry into bit0, bit7 out
// - rotate right: carry into bit7, bit0 out
// - destination zero writes accumulator, file untouched
// - destination one writes back same file register
// - each rotate finishes in one cycle
`timescale 1ns/1ps
`default_nettype none
module return_and_rotate_exec (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        instr_valid,
  input  wire logic [13:0] instr,
  output logic             instr_ready,
  input  wire logic [12:0] stack_top_entry,
  output logic             stack_pop,
  output logic             pc_load,
  output logic      [12:0] pc_value,
  output logic      [6:0]  file_raddr,
  input  wire logic [7:0]  file_rdata,
  input  wire logic        carry_in,
  output logic             w_we,
  output logic             file_we,
  output logic      [6:0]  file_waddr,
  output logic      [7:0]  result_data,
  output logic             carry_we,
  output logic             carry_out
);

  // ****************************************
  // decode
  // ****************************************
  ret_rot_pkg::exec_s st_r;
  ret_rot_pkg::exec_s st_nxt;
  logic       take;
  logic       is_ret;
  logic       is_rl;
  logic       is_rr;
  logic       dest_f;
  logic [7:0] rot_data;
  logic       rot_carry;

  // a second return cycle blocks the next word, so the caller sees back-pressure
  assign instr_ready = (st_r.phase == ret_rot_pkg::PH_FETCH);
  assign take        = instr_valid && instr_ready;
  assign is_ret      = (instr == ret_rot_pkg::OPC_RETURN);
  assign is_rl       = (instr[ret_rot_pkg::OPC_HI:ret_rot_pkg::OPC_LO]
                        == ret_rot_pkg::OPC_ROT_LEFT);
  assign is_rr       = (instr[ret_rot_pkg::OPC_HI:ret_rot_pkg::OPC_LO]
                        == ret_rot_pkg::OPC_ROT_RIGHT);
  assign dest_f      = instr[ret_rot_pkg::DEST_BIT];
  // read address is driven during the decode cycle so the file answers in time
  assign file_raddr  = instr[ret_rot_pkg::FADDR_HI:0];

  rotate_unit u_rot (
    .to_left   (is_rl),
    .data_in   (file_rdata),
    .carry_in  (carry_in),
    .data_out  (rot_data),
    .carry_out (rot_carry)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt         = st_r;
    st_nxt.pop     = 1'b0;
    st_nxt.pc_load = 1'b0;
    st_nxt.w_we    = 1'b0;
    st_nxt.f_we    = 1'b0;
    st_nxt.c_we    = 1'b0;
    case (st_r.phase)
      ret_rot_pkg::PH_FETCH: begin
        if (take && is_ret) begin
          st_nxt.pop     = 1'b1;
          st_nxt.pc_load = 1'b1;
          st_nxt.pc      = stack_top_entry;
          st_nxt.phase   = ret_rot_pkg::PH_RET_NOP;
        end else if (take && (is_rl || is_rr)) begin
          st_nxt.result = rot_data;
          st_nxt.c_val  = rot_carry;
          st_nxt.c_we   = 1'b1;
          st_nxt.f_addr = instr[ret_rot_pkg::FADDR_HI:0];
          st_nxt.w_we   = (dest_f == ret_rot_pkg::DEST_TO_W);
          st_nxt.f_we   = (dest_f != ret_rot_pkg::DEST_TO_W);
        end
      end
      ret_rot_pkg::PH_RET_NOP: begin
        st_nxt.phase = ret_rot_pkg::PH_FETCH;
      end
      default: begin
        st_nxt.phase = ret_rot_pkg::PH_FETCH;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= ret_rot_pkg::EXEC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stack_pop   = st_r.pop;
  assign pc_load     = st_r.pc_load;
  assign pc_value    = st_r.pc;
  assign w_we        = st_r.w_we;
  assign file_we     = st_r.f_we;
  assign file_waddr  = st_r.f_addr;
  assign result_data = st_r.result;
  assign carry_we    = st_r.c_we;
  assign carry_out   = st_r.c_val;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ****************************************
  // return checks
  // ****************************************
  chk_ret_pop_pc: assert property (
    take && is_ret |=> stack_pop && pc_load && pc_value == $past(stack_top_entry))
    else $error("return did not load pc from stack top");

  chk_ret_no_flags: assert property (
    take && is_ret |=> !carry_we && !w_we && !file_we)
    else $error("return touched flags or data");

  chk_pop_pairs: assert property (
    stack_pop == pc_load)
    else $error("stack pop and pc load came apart");

  // pc only ever moves on a return, so any other cycle must leave it alone
  chk_pc_hold: assert property (
    !(take && is_ret) |=> pc_value == $past(pc_value))
    else $error("pc value moved without a return");

  chk_ret_two_cyc: assert property (
    take && is_ret |=> !instr_ready ##1 (instr_ready && !stack_pop && !pc_load))
    else $error("return did not take exactly two cycles");

  chk_pop_single: assert property (
    stack_pop |=> !stack_pop)
    else $error("stack popped in two cycles running");

  chk_refused_word: assert property (
    !instr_ready |=> !stack_pop && !pc_load && !carry_we && !w_we && !file_we)
    else $error("word offered in the dead cycle was executed");

  // ****************************************
  // rotate checks
  // ****************************************
  chk_rot_left: assert property (
    take && is_rl |=> carry_we && result_data == {$past(file_rdata[6:0]), $past(carry_in)}
                      && carry_out == $past(file_rdata[7]))
    else $error("rotate left result wrong");

  chk_rot_right: assert property (
    take && is_rr |=> carry_we && result_data == {$past(carry_in), $past(file_rdata[7:1])}
                      && carry_out == $past(file_rdata[0]))
    else $error("rotate right result wrong");

  chk_rot_keeps_pc: assert property (
    take && (is_rl || is_rr) |=> !stack_pop && !pc_load && pc_value == $past(pc_value))
    else $error("rotate disturbed the program counter");

  chk_dest_accum: assert property (
    take && (is_rl || is_rr) && !instr[7] |=> w_we && !file_we)
    else $error("destination zero did not go to accumulator only");

  chk_dest_file: assert property (
    take && (is_rl || is_rr) && instr[7] |=> file_we && !w_we
                                           && file_waddr == $past(instr[6:0]))
    else $error("destination one did not write back source register");

  chk_one_dest: assert property (
    !(w_we && file_we))
    else $error("result written to both destinations");

  chk_rot_single: assert property (
    take && (is_rl || is_rr) |=> instr_ready && !stack_pop)
    else $error("rotate took more than one cycle");

  chk_result_hold: assert property (
    !(take && (is_rl || is_rr)) |=> result_data == $past(result_data)
                                    && carry_out == $past(carry_out)
                                    && file_waddr == $past(file_waddr))
    else $error("rotate outputs moved without a rotate");

  // ****************************************
  // decode and reset checks
  // ****************************************
  chk_read_addr: assert property (
    instr_valid |-> file_raddr == instr[6:0])
    else $error("file read address not from bits six to zero");

  chk_other_quiet: assert property (
    take && !is_ret && !is_rl && !is_rr
    |=> !stack_pop && !pc_load && !carry_we && !w_we && !file_we)
    else $error("unknown opcode produced a pulse");

  // reset itself is the subject here, so the default disable is lifted
  chk_reset_quiet: assert property (
    disable iff (1'b0) rst
    |=> instr_ready && !stack_pop && !pc_load && !carry_we && !w_we && !file_we)
    else $error("outputs not quiet under reset");

  // ****************************************
  // covers
  // ****************************************
  cov_return: cover property (take && is_ret ##2 take);
  cov_rl_w: cover property (take && is_rl && !instr[7]);
  cov_rl_f: cover property (take && is_rl && dest_f);
  cov_rr_w: cover property (take && is_rr && !dest_f);
  cov_rr_f: cover property (take && is_rr && instr[7]);

endmodule
`default_nettype wire

/* verification/testbench.sv */
// Purpose: self-checking bench for return_and_rotate_exec
// Assumes: inputs change by nba at the rising edge, outputs read after 1 ns or at the fall
// Notes:   no far-side model, the bench plays stack, file and carry
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****************************************
  // signals
  // ****************************************
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        instr_valid = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic [12:0] stack_top_entry = 13'h0000;
  logic [7:0]  file_rdata = 8'h00;
  logic        carry_in = 1'b0;
  logic        instr_ready, stack_pop, pc_load, w_we, file_we, carry_we, carry_out;
  logic [12:0] pc_value;
  logic [6:0]  file_raddr, file_waddr;
  logic [7:0]  result_data;
  int          err_total = 0;
  int          n_compared = 0;
  logic [7:0]  pend_r = 8'h00;
  logic        pend_c = 1'b0;
  logic        pend_dst = 1'b0;
  logic        pend_live = 1'b0;
  logic [6:0]  pend_fa = 7'h00;

  return_and_rotate_exec i_return_and_rotate_exec (.clock(clock), .rst(rst),
    .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
    .stack_top_entry(stack_top_entry), .stack_pop(stack_pop), .pc_load(pc_load),
    .pc_value(pc_value), .file_raddr(file_raddr), .file_rdata(file_rdata),
    .carry_in(carry_in), .w_we(w_we), .file_we(file_we), .file_waddr(file_waddr),
    .result_data(result_data), .carry_we(carry_we), .carry_out(carry_out));

  initial begin
    forever #12.5 clock = ~clock;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // a rotate offered during the dead cycle must be refused, not executed
  task automatic t_return(input logic [12:0] top);
    @(posedge clock);
    instr <= 14'h0008;
    instr_valid <= 1'b1;
    stack_top_entry <= top;
    @(posedge clock);
    instr <= 14'h0d80;
    stack_top_entry <= ~top;
    #1;
    chk("stack_pop", 13'h0001, {12'h000, stack_pop});
    chk("pc_load", 13'h0001, {12'h000, pc_load});
    chk("pc_value", top, pc_value);
    chk("carry_we", 13'h0000, {12'h000, carry_we});
    chk("instr_ready", 13'h0000, {12'h000, instr_ready});
    @(posedge clock);
    instr_valid <= 1'b0;
    #1;
    chk("pop_again", 13'h0000, {12'h000, stack_pop | pc_load});
    chk("nop_writes", 13'h0000, {12'h000, w_we | file_we | carry_we});
    chk("pc_hold", top, pc_value);
    chk("ready_back", 13'h0001, {12'h000, instr_ready});
    @(posedge clock);
    $display("return test done");
  endtask

  // pulses of a rotate stand only in the cycle after its taking edge, so they are judged there
  task automatic rot_results();
    if (pend_live) begin
      chk("result_data", {5'h00, pend_r}, {5'h00, result_data});
      chk("carry_out", {12'h000, pend_c}, {12'h000, carry_out});
      chk("carry_we", 13'h0001, {12'h000, carry_we});
      chk("rot_pop", 13'h0000, {12'h000, stack_pop | pc_load});
      chk("w_we", {12'h000, ~pend_dst}, {12'h000, w_we});
      chk("file_we", {12'h000, pend_dst}, {12'h000, file_we});
      if (pend_dst) begin
        chk("file_waddr", {6'h00, pend_fa}, {6'h00, file_waddr});
      end
    end
    pend_live = 1'b0;
  endtask

  // called at a rising edge; returns at the taking edge so rotates run back to back
  task automatic t_rotate(input logic lft, input logic dst, input logic [6:0] fa,
                          input logic [7:0] d, input logic c);
    instr <= {2'b00, (lft ? 4'hd : 4'hc), dst, fa};
    instr_valid <= 1'b1;
    file_rdata <= d;
    carry_in <= c;
    @(negedge clock);
    rot_results();
    chk("file_raddr", {6'h00, fa}, {6'h00, file_raddr});
    pend_r = lft ? {d[6:0], c} : {c, d[7:1]};
    pend_c = lft ? d[7] : d[0];
    pend_dst = dst;
    pend_fa = fa;
    pend_live = 1'b1;
    @(posedge clock);
  endtask

  // back-to-back rotates over both directions, destinations and carries
  task automatic t_rotate_table();
    logic [6:0] fa;
    logic [7:0] d;
    @(posedge clock);
    for (int k = 0; k < 8; k++) begin
      fa = 7'(7'h7f - k * 7'h11);
      d = 8'(8'he6 ^ (k * 8'h25));
      t_rotate(k[2], k[1], fa, d, k[0]);
    end
    t_rotate(1'b1, 1'b0, 7'h00, 8'h80, 1'b0);
    t_rotate(1'b0, 1'b1, 7'h7f, 8'h01, 1'b1);
    t_rotate(1'b1, 1'b0, 7'h0c, 8'he6, 1'b0);
    t_rotate(1'b0, 1'b0, 7'h0c, 8'he6, 1'b0);
    instr <= 14'h0009;
    @(negedge clock);
    rot_results();
    @(posedge clock);
    instr_valid <= 1'b0;
    @(negedge clock);
    chk("pulse_end", 13'h0000, {12'h000, carry_we | w_we | file_we | stack_pop});
    @(posedge clock);
    $display("rotate test done");
  endtask

  // reset in the dead cycle of a return drops the pop and reopens the port at once
  task automatic t_mid_reset();
    @(posedge clock);
    instr <= 14'h0008;
    instr_valid <= 1'b1;
    stack_top_entry <= 13'h0f0f;
    @(posedge clock);
    instr_valid <= 1'b0;
    rst <= 1'b1;
    #1;
    chk("rst_pulses", 13'h0000, {12'h000, stack_pop | pc_load | carry_we});
    chk("rst_pc", 13'h0000, pc_value);
    chk("rst_ready", 13'h0001, {12'h000, instr_ready});
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    instr_valid <= 1'b1;
    stack_top_entry <= 13'h0a5a;
    @(posedge clock);
    instr_valid <= 1'b0;
    #1;
    chk("rst_first_pop", 13'h0001, {12'h000, stack_pop});
    chk("rst_first_pc", 13'h0a5a, pc_value);
    @(posedge clock);
    $display("mid reset test done");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk("reset_pc", 13'h0000, pc_value);
    chk("reset_ready", 13'h0001, {12'h000, instr_ready});
    t_return(13'h1abc);
    t_rotate_table();
    t_return(13'h0543);
    t_mid_reset();
    close_out();
  end
endmodule
`default_nettype wire
